//--- logic/twe_pkg.sv
package twe_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int WRITE_TIME_MS = 5;
    // Typical self-timed write, rounded up to whole core cycles
    localparam int WRITE_CYCLES =
        (WRITE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Array and address layout
    // ----------------------------------------------------------------
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int PAGE_W = 2;
    localparam int PAGE_BYTES = 4;
    localparam int FIFO_DEPTH = 2;
    localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // Slave address byte fields
    localparam int SLV_RW_BIT = 0;
    localparam int SLV_SEL_LSB = 1;
    localparam int SLV_TYPE_LSB = 4;
    // Device type code: value is arbitrary
    localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h5;

    // ----------------------------------------------------------------
    // Slave sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_DEV_ADDR,
        ST_DEV_ACK,
        ST_WORD_ADDR,
        ST_WORD_ACK,
        ST_WR_DATA,
        ST_WR_ACK,
        ST_RD_DATA,
        ST_RD_ACK
    } twe_state_t;

endpackage

//--- logic/twe_slave.sv
// Operation
// - Data changes only while clock low
// - Start is falling data, clock high
// - Stop after read enters standby
// - Receiver pulls data low on ninth clock
// - Acknowledge only own slave address
// - Acknowledge every written byte
// - Read shifts eight bits, samples ninth
// - No master acknowledge ends transmission
// - Upper four address bits match type
// - Next three bits match select straps
// - Last bit selects read or write
// - Word address uses lower seven bits
// - Stop after data starts internal write
// - Ignore everything during internal write
// - Page write accepts up to four bytes
// - Increment low two bits, wrap page
// - Write inhibit high blocks all writes
// - Busy device refuses acknowledge; polling works
// - Counter holds last address plus one
// - Sequential read wraps top to zero
module twe_slave #(
    parameter int WRITE_CYCLES = twe_pkg::WRITE_CYCLES,
    parameter int FIFO_DEPTH = twe_pkg::FIFO_DEPTH,
    parameter logic [3:0] DEV_TYPE = twe_pkg::DEV_TYPE_DEFAULT
) (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic SCL,
    input wire logic SDA,
    output logic SDA_VAL,
    output logic SDA_OE,
    input wire logic SELECT_STRAP_BIT0,
    input wire logic SELECT_STRAP_BIT1,
    input wire logic SELECT_STRAP_BIT2,
    input wire logic WRITE_INHIBIT_IN,
    output logic WRITE_BUSY,
    output logic STANDBY_MODE
);

    localparam int TMR_W = $clog2(WRITE_CYCLES + 1);
    localparam int FP_W = $clog2(FIFO_DEPTH);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (WRITE_CYCLES < 1 || FIFO_DEPTH < 2 ||
        (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_param
        $error("WRITE_CYCLES or FIFO_DEPTH out of range");
    end
    function automatic logic is_ack(input twe_pkg::twe_state_t s);
        is_ack = (s == twe_pkg::ST_DEV_ACK) || (s == twe_pkg::ST_WORD_ACK) ||
                 (s == twe_pkg::ST_WR_ACK) || (s == twe_pkg::ST_RD_ACK);
    endfunction
    function automatic logic is_rx(input twe_pkg::twe_state_t s);
        is_rx = (s == twe_pkg::ST_DEV_ADDR) || (s == twe_pkg::ST_WORD_ADDR) ||
                (s == twe_pkg::ST_WR_DATA);
    endfunction
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
    logic [2:0] strap_m, strap_s;
    logic inhib_m, inhib_s;
    // Two stages before use; third stage only for edge finding
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            {scl_m, scl_s, scl_d} <= 3'h7;
            {sda_m, sda_s, sda_d} <= 3'h7;
            {strap_m, strap_s} <= 6'h00;
            {inhib_m, inhib_s} <= 2'h3;
        end else begin
            {scl_m, scl_s, scl_d} <= {SCL, scl_m, scl_s};
            {sda_m, sda_s, sda_d} <= {SDA, sda_m, sda_s};
            strap_m <= {SELECT_STRAP_BIT2, SELECT_STRAP_BIT1, SELECT_STRAP_BIT0};
            strap_s <= strap_m;
            inhib_m <= WRITE_INHIBIT_IN;
            inhib_s <= inhib_m;
        end
    end

    // ----------------------------------------------------------------
    // Line events and decode
    // ----------------------------------------------------------------
    twe_pkg::twe_state_t state;
    logic [2:0] bit_cnt;
    logic ack_phase, rw, master_ack, wr_session, busy;
    logic [7:0] rx_shift, tx_shift;
    logic [6:0] word_addr, addr_cnt, fetch_addr;
    logic [3:0] page_valid;
    logic [7:0] page_data [twe_pkg::PAGE_BYTES];
    logic [7:0] mem [2**twe_pkg::ADDR_W];
    logic [TMR_W-1:0] timer;
    logic [7:0] fifo_mem [FIFO_DEPTH];
    logic [FP_W:0] wptr, rptr;

    // Edges seen only in the synchronised view, so glitches wider
    // than a core cycle still count; the master must keep data stable
    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_det = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_det = scl_s & scl_d & ~sda_d & sda_s;
    wire start_ok = start_det & ~busy;
    wire [7:0] rx_byte = {rx_shift[6:0], sda_s};
    wire rx_last = scl_rise & (bit_cnt == twe_pkg::LAST_BIT);
    wire byte_done = rx_last & is_rx(state);
    wire type_ok = rx_byte[7:twe_pkg::SLV_TYPE_LSB] == DEV_TYPE;
    wire sel_ok = rx_byte[3:twe_pkg::SLV_SEL_LSB] == strap_s;
    wire addr_match = type_ok & sel_ok;
    wire ack_end = scl_fall & is_ack(state) & ack_phase;
    wire ack_begin = scl_fall & is_ack(state) & ~ack_phase;
    wire enter_rd = ack_end & (((state == twe_pkg::ST_DEV_ACK) & rw) |
                               ((state == twe_pkg::ST_RD_ACK) & master_ack));
    wire wr_byte = byte_done & (state == twe_pkg::ST_WR_DATA);

    // Next state after the ninth clock ends
    wire twe_pkg::twe_state_t after_ack =
        (state == twe_pkg::ST_DEV_ACK) ?
            (rw ? twe_pkg::ST_RD_DATA : twe_pkg::ST_WORD_ADDR) :
        (state == twe_pkg::ST_RD_ACK) ?
            (master_ack ? twe_pkg::ST_RD_DATA : twe_pkg::ST_IDLE) :
        twe_pkg::ST_WR_DATA;

    // Next state after a complete byte; a foreign address goes idle
    wire twe_pkg::twe_state_t after_byte =
        (state == twe_pkg::ST_DEV_ADDR) ?
            (addr_match ? twe_pkg::ST_DEV_ACK : twe_pkg::ST_IDLE) :
        (state == twe_pkg::ST_WORD_ADDR) ? twe_pkg::ST_WORD_ACK :
        (state == twe_pkg::ST_WR_DATA) ? twe_pkg::ST_WR_ACK :
        twe_pkg::ST_RD_ACK;

    // Page low bits roll over inside the page
    wire [1:0] next_low = word_addr[1:0] + 2'h1;
    wire [6:0] next_waddr = {word_addr[6:2], next_low};
    wire commit = stop_det & wr_session & (page_valid != 4'h0) &
                  ~inhib_s & ~busy;

    // ----------------------------------------------------------------
    // Read prefetch buffer
    // ----------------------------------------------------------------
    wire [FP_W:0] fifo_cnt = wptr - rptr;
    wire fifo_full = fifo_cnt == (FP_W + 1)'(FIFO_DEPTH);
    wire fifo_valid = fifo_cnt != '0;
    wire fill_valid = ~busy;
    wire fill_ready = ~fifo_full;
    // Fetch stalls while full, so a slow master loses no word
    wire push = fill_valid & fill_ready & ~start_det;
    wire pop = enter_rd & fifo_valid;
    wire [7:0] head = fifo_mem[rptr[FP_W-1:0]];
    // An empty buffer cannot occur at bus rates; idle bus level is sent
    wire [7:0] tx_load = fifo_valid ? head : 8'hFF;

    // Flushed on every start so the fetch restarts at the counter
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            wptr <= '0;
            rptr <= '0;
            fetch_addr <= twe_pkg::ADDR_RST;
        end else if (start_det) begin
            wptr <= '0;
            rptr <= '0;
            fetch_addr <= addr_cnt;
        end else begin
            wptr <= wptr + (FP_W + 1)'(push);
            rptr <= rptr + (FP_W + 1)'(pop);
            fetch_addr <= fetch_addr + 7'(push);
        end
    end

    // Buffer storage, no reset needed
    always_ff @(posedge CORE_CLK) begin
        if (push) begin
            fifo_mem[wptr[FP_W-1:0]] <= mem[fetch_addr];
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state <= twe_pkg::ST_IDLE;
            bit_cnt <= 3'h0;
            ack_phase <= 1'b0;
        end else if (start_ok) begin
            state <= twe_pkg::ST_DEV_ADDR;
            bit_cnt <= 3'h0;
            ack_phase <= 1'b0;
        end else if (stop_det) begin
            state <= twe_pkg::ST_IDLE;
            ack_phase <= 1'b0;
        end else if (is_ack(state)) begin
            if (ack_end) begin
                state <= after_ack;
            end
            ack_phase <= ack_phase ^ scl_fall;
        end else if (scl_rise && state != twe_pkg::ST_IDLE) begin
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == twe_pkg::LAST_BIT) begin
                state <= after_byte;
            end
        end
    end

    // Receive shift, direction and master acknowledge sampling
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rx_shift <= 8'h00;
            rw <= 1'b0;
            master_ack <= 1'b0;
        end else begin
            if (scl_rise && is_rx(state)) begin
                rx_shift <= rx_byte;
            end
            if (byte_done && state == twe_pkg::ST_DEV_ADDR) begin
                rw <= rx_byte[twe_pkg::SLV_RW_BIT];
            end
            if (scl_rise && state == twe_pkg::ST_RD_ACK) begin
                master_ack <= ~sda_s;
            end
        end
    end

    // ----------------------------------------------------------------
    // Open-drain data driver
    // ----------------------------------------------------------------
    // Drive changes only on clock falls, except the release on start or stop with clock high
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            SDA_OE <= 1'b0;
            SDA_VAL <= 1'b0;
            tx_shift <= 8'h00;
        end else if (start_det || stop_det) begin
            SDA_OE <= 1'b0;
        end else if (ack_begin) begin
            // Pull low for receive acks, release for the master's
            SDA_OE <= state != twe_pkg::ST_RD_ACK;
        end else if (enter_rd) begin
            tx_shift <= tx_load;
            SDA_OE <= ~tx_load[7];
        end else if (ack_end) begin
            SDA_OE <= 1'b0;
        end else if (scl_fall && state == twe_pkg::ST_RD_DATA) begin
            tx_shift <= {tx_shift[6:0], 1'b0};
            SDA_OE <= ~tx_shift[6];
        end
    end

    // ----------------------------------------------------------------
    // Address counter and page latch
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            word_addr <= twe_pkg::ADDR_RST;
            addr_cnt <= twe_pkg::ADDR_RST;
            page_valid <= 4'h0;
            wr_session <= 1'b0;
        end else begin
            if (start_det || stop_det) begin
                wr_session <= 1'b0;
            end else if (ack_end && state == twe_pkg::ST_DEV_ACK && !rw) begin
                wr_session <= 1'b1;
            end
            if (start_ok || stop_det) begin
                page_valid <= 4'h0;
            end else if (wr_byte) begin
                page_valid[word_addr[1:0]] <= 1'b1;
            end
            if (byte_done && state == twe_pkg::ST_WORD_ADDR) begin
                word_addr <= rx_byte[6:0];
                addr_cnt <= rx_byte[6:0];
            end else if (wr_byte) begin
                word_addr <= next_waddr;
                addr_cnt <= next_waddr;
            end else if (pop) begin
                addr_cnt <= addr_cnt + 7'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // Page data latch, nonvolatile array and self-timed write
    // ----------------------------------------------------------------
    // One process owns the array; busy window only models cell time
    always_ff @(posedge CORE_CLK) begin
        if (wr_byte) begin
            page_data[word_addr[1:0]] <= rx_byte;
        end
        for (int i = 0; i < twe_pkg::PAGE_BYTES; i++) begin
            if (commit && page_valid[i]) begin
                mem[{word_addr[6:2], 2'(i)}] <= page_data[i];
            end
        end
    end
    // Busy window, standby and status outputs
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            busy <= 1'b0;
            timer <= '0;
            WRITE_BUSY <= 1'b0;
            STANDBY_MODE <= 1'b1;
        end else begin
            if (commit) begin
                busy <= 1'b1;
                timer <= TMR_W'(WRITE_CYCLES - 1);
            end else if (busy) begin
                timer <= timer - TMR_W'(1);
                busy <= timer != '0;
            end
            WRITE_BUSY <= commit | (busy & (timer != '0));
            if (stop_det) begin
                STANDBY_MODE <= 1'b1;
            end else if (start_ok) begin
                STANDBY_MODE <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);
    sequence s_addr_hit;
        byte_done && state == twe_pkg::ST_DEV_ADDR && addr_match;
    endsequence
    sequence s_ack_open;
        scl_fall && state == twe_pkg::ST_DEV_ACK && !ack_phase;
    endsequence
    sequence s_busy_hold;
        busy [*8];
    endsequence
    chk_foreign_silent: assert property (
        byte_done && state == twe_pkg::ST_DEV_ADDR && !addr_match
        |=> state == twe_pkg::ST_IDLE && !SDA_OE)
        else $error("device answered a foreign address");
    chk_addr_ack: assert property (
        s_addr_hit ##[1:64] s_ack_open |=> SDA_OE)
        else $error("matched address not acknowledged");
    chk_busy_ignore: assert property (
        busy |-> state == twe_pkg::ST_IDLE && !SDA_OE)
        else $error("device reacted during internal write");
    chk_stop_standby: assert property (
        stop_det |=> state == twe_pkg::ST_IDLE && STANDBY_MODE)
        else $error("stop did not return to standby");
    chk_start_begin: assert property (
        start_ok |=> state == twe_pkg::ST_DEV_ADDR && bit_cnt == 3'h0)
        else $error("start not taken");
    chk_inhibit_write: assert property (
        stop_det && inhib_s && !busy |=> !busy && !WRITE_BUSY)
        else $error("write started while inhibited");
    chk_write_start: assert property (
        commit |=> s_busy_hold or (busy ##1 !busy))
        else $error("internal write not started");
    chk_page_wrap: assert property (
        wr_byte |=> word_addr[6:2] == $past(word_addr[6:2]) &&
            word_addr[1:0] == 2'($past(word_addr[1:0]) + 2'h1))
        else $error("page address stepped wrongly");
    chk_read_step: assert property (
        pop && !wr_byte |=> addr_cnt == 7'($past(addr_cnt) + 7'h01))
        else $error("read counter did not advance");
    chk_drive_low: assert property (
        $changed(SDA_OE) |-> !$past(scl_s) ||
            $past(start_det) || $past(stop_det))
        else $error("data drive changed with clock high");
endmodule

//--- testbench/twe_master_model.sv
// Bus master model: drives the serial clock and pulls data low when asked
module twe_master_model (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic pull
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // Line timing
    // ----------------------------------------------------------------
    // Idle bus: clock high, data released to the pull-up
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // One bit: low 6 cycles, high 2; data moves only while clock low
    task automatic bit_cycle(input logic b, output logic got);
        @(posedge clk);
        scl <= 1'b0;
        tick(1);
        pull <= ~b;
        tick(5);
        scl <= 1'b1;
        tick(1);
        got = sda;
    endtask

    // Data falls while clock high; also serves as repeated start
    task automatic start();
        @(posedge clk);
        scl <= 1'b0;
        tick(1);
        pull <= 1'b0;
        tick(5);
        scl <= 1'b1;
        tick(3);
        pull <= 1'b1;
        tick(3);
    endtask

    // Data rises while clock high; slave has already let go
    task automatic stop();
        @(posedge clk);
        scl <= 1'b0;
        tick(1);
        pull <= 1'b1;
        tick(5);
        scl <= 1'b1;
        tick(3);
        pull <= 1'b0;
        tick(6);
    endtask

    // ----------------------------------------------------------------
    // Byte transfers, most significant bit first
    // ----------------------------------------------------------------
    // Ninth clock with data released so the slave can answer
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(b[i], g);
        end
        bit_cycle(1'b1, g);
        ack = ~g;
    endtask

    // Leaving data high on the ninth clock ends the read
    task automatic rbyte(input logic ack_out, output logic [7:0] b);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, g);
            b[i] = g;
        end
        bit_cycle(~ack_out, g);
    endtask
endmodule

//--- testbench/twe_slave_tb.sv
module twe_slave_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // Bench wiring
    // ----------------------------------------------------------------
    // Long enough that a poll lands inside the busy window
    localparam int WCYC = 400;
    logic core_clk;
    logic rst_b;
    logic [2:0] strap;
    logic inhibit;
    logic sda_val;
    logic sda_oe;
    logic write_busy;
    logic standby_mode;
    logic scl;
    logic m_pull;
    wire sda_bus;
    int miscompares;
    int checked;
    int cycles;

    // Pull-up: any party pulling low wins
    assign sda_bus = ~((sda_oe & ~sda_val) | m_pull);

    twe_master_model m (.clk(core_clk), .sda(sda_bus), .scl(scl),
        .pull(m_pull));

    twe_slave #(.WRITE_CYCLES(WCYC)) uut (
        .CORE_CLK(core_clk), .RST_B(rst_b), .SCL(scl), .SDA(sda_bus),
        .SDA_VAL(sda_val), .SDA_OE(sda_oe),
        .SELECT_STRAP_BIT0(strap[0]), .SELECT_STRAP_BIT1(strap[1]),
        .SELECT_STRAP_BIT2(strap[2]), .WRITE_INHIBIT_IN(inhibit),
        .WRITE_BUSY(write_busy), .STANDBY_MODE(standby_mode));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Cut a hang short well past the expected run
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            miscompares++;
            $display("mismatch at %0t: run timed out", $time);
            end_sim();
        end
    end

    // ----------------------------------------------------------------
    // Compare and bus helpers
    // ----------------------------------------------------------------
    task automatic cmp_bit(input logic got, input logic exp,
        input string what);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp,
        input string what);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h", $time, what, got);
        end
    endtask

    function automatic logic [7:0] slv(input logic rw);
        return {twe_pkg::DEV_TYPE_DEFAULT, strap, rw};
    endfunction

    // Outputs are judged half a cycle after the edge that moves them
    task automatic settle();
        @(negedge core_clk);
    endtask

    task automatic send_addr(input logic [7:0] a, input logic exp_ack);
        logic ack;
        m.start();
        m.wbyte(a, ack);
        cmp_bit(ack, exp_ack, "address ack");
    endtask

    task automatic page_write(input logic [7:0] wa, input logic [7:0] d[$]);
        logic ack;
        send_addr(slv(1'b0), 1'b1);
        m.wbyte(wa, ack);
        cmp_bit(ack, 1'b1, "word address ack");
        foreach (d[i]) begin
            m.wbyte(d[i], ack);
            cmp_bit(ack, 1'b1, "data ack");
        end
        m.stop();
    endtask

    // Bounded wait for the internal write to finish
    task automatic wait_idle();
        int n;
        n = 0;
        while (write_busy !== 1'b0 && n < WCYC + 200) begin
            @(posedge core_clk);
            n++;
        end
        settle();
        cmp_bit(write_busy, 1'b0, "busy end");
    endtask

    // Dummy write sets the counter, repeated start reads; last byte nacked
    task automatic read_seq(input logic [7:0] wa, input logic [7:0] e[$]);
        logic ack;
        logic [7:0] b;
        send_addr(slv(1'b0), 1'b1);
        m.wbyte(wa, ack);
        send_addr(slv(1'b1), 1'b1);
        foreach (e[i]) begin
            m.rbyte(i != e.size() - 1, b);
            cmp_byte(b, e[i], "read data");
        end
        m.stop();
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_byte_write();
        page_write(8'h85, '{8'hA5});
        settle();
        cmp_bit(write_busy, 1'b1, "busy after stop");
        send_addr(slv(1'b0), 1'b0);
        m.stop();
        wait_idle();
        send_addr(slv(1'b0), 1'b1);
        settle();
        cmp_bit(standby_mode, 1'b0, "active in transfer");
        m.stop();
        read_seq(8'h05, '{8'hA5});
        settle();
        cmp_bit(standby_mode, 1'b1, "standby after read");
    endtask

    // Each single flipped type or select bit must go unanswered
    task automatic t_foreign();
        logic ack;
        m.wbyte(slv(1'b0), ack);
        cmp_bit(ack, 1'b0, "byte without start");
        m.stop();
        for (int i = 1; i < 8; i++) begin
            send_addr(slv(1'b0) ^ (8'h01 << i), 1'b0);
            m.stop();
        end
        settle();
        cmp_bit(write_busy, 1'b0, "no write without data");
        @(posedge core_clk);
        strap <= 3'b010;
        settle();
        send_addr(slv(1'b0), 1'b1);
        m.stop();
    endtask

    // Five bytes from 0x0A wrap within the page at 0x08
    task automatic t_page();
        logic [7:0] b;
        page_write(8'h0A, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55});
        wait_idle();
        send_addr(slv(1'b1), 1'b1);
        m.rbyte(1'b0, b);
        cmp_byte(b, 8'h22, "current address read");
        m.stop();
        read_seq(8'h08, '{8'h33, 8'h44, 8'h55, 8'h22});
    endtask

    task automatic t_inhibit();
        inhibit <= 1'b1;
        page_write(8'h08, '{8'h99});
        settle();
        cmp_bit(write_busy, 1'b0, "no busy when inhibited");
        @(posedge core_clk);
        inhibit <= 1'b0;
        read_seq(8'h08, '{8'h33});
    endtask

    // Read counter rolls from the top address to zero; nack silences
    task automatic t_wrap();
        logic [7:0] b;
        page_write(8'h7F, '{8'h77});
        wait_idle();
        page_write(8'h00, '{8'h66, 8'h5A});
        wait_idle();
        read_seq(8'h7F, '{8'h77, 8'h66});
        send_addr(slv(1'b1), 1'b1);
        m.rbyte(1'b0, b);
        cmp_byte(b, 8'h5A, "current read after wrap");
        m.rbyte(1'b0, b);
        cmp_byte(b, 8'hFF, "silent after nack");
        m.stop();
    endtask

    task automatic end_sim();
        $display("checked %0d, miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        strap = 3'b101;
        inhibit = 1'b0;
        miscompares = 0;
        checked = 0;
        cycles = 0;
        repeat (3) @(posedge core_clk);
        settle();
        cmp_bit(sda_oe, 1'b0, "bus released in reset");
        cmp_bit(write_busy, 1'b0, "idle in reset");
        cmp_bit(standby_mode, 1'b1, "standby in reset");
        @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge core_clk);
        t_byte_write();
        t_foreign();
        t_page();
        t_inhibit();
        t_wrap();
        end_sim();
    end
endmodule
